// File: csec_pkg.sv
// constants and types shared by the sync and exposure control block
package csec_pkg;
  localparam logic [7:0] ADDR_COM1   = 8'h00;
  localparam logic [7:0] ADDR_CLKDIV = 8'h01;
  localparam logic [7:0] ADDR_CTRL   = 8'h02;
  localparam logic [7:0] ADDR_STAT   = 8'h03;
  localparam int         COM1_SLAVE_BIT = 6;
  localparam int         COM1_PROG_BIT  = 2;
  localparam int         CTRL_SRST_BIT  = 0;
  localparam int         CTRL_SPD_BIT   = 1;
  localparam int         STAT_CLR_BIT   = 7;
  localparam int         STRAP_SLAVE_BIT = 0;
  localparam int         STRAP_PROG_BIT  = 1;
  localparam logic [7:0] COM1_RST   = 8'h00;
  localparam logic [5:0] CLKDIV_RST = 6'h00;
  localparam logic       SPD_RST    = 1'b0;
  localparam int         CLKDIV_W   = 6;
  localparam int         XCLK_NOM_KHZ = 17730;
  localparam int         PRECH_LINE_MUL = 292;
  localparam int         PRECH_MUL      = 4;
  localparam int         PRECH_PIX      = PRECH_LINE_MUL * PRECH_MUL;
  localparam int         HOLD_LINES     = 4;
  localparam int         DUMMY_LINES    = 8;
  localparam logic [1:0] STRAP_SETTLE   = 2'h3;
  localparam int         SYNC_PINS      = 7;

  typedef enum logic [2:0] {EXP_IDLE, EXP_PRECH, EXP_INTEG, EXP_DUMMY, EXP_READ} csec_exp_t;

  typedef struct packed {
    logic hs;
    logic vs;
  } csec_sync_t;
endpackage

// File: csec_top.sv
// sync, frame exposure, reset, power-down and strap control of the sensor core
`timescale 1ns/10ps
module csec_top
  import csec_pkg::*;
#(
  parameter int LINE_PIX    = 400,
  parameter int HS_PIX      = 32,
  parameter int FRAME_LINES = 312,
  parameter int VS_LINES    = 3,
  parameter int ACT_START   = 40,
  parameter int ACT_PIX     = 356,
  parameter int ACT_LINES   = 292
)
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       reset_pin,
  input  wire logic       power_down_pin,
  input  wire logic       frame_exposure_input,
  input  wire logic [1:0] strap_pins,
  input  wire csec_sync_t sync_in,
  output csec_sync_t      sync_out,
  output csec_sync_t      sync_oe,
  output logic            line_valid,
  output logic            precharge_active,
  output logic            integrating
);

  // reset, power-down, exposure, sync and strap pins pass two flops before use; bus pins do not
  logic [SYNC_PINS-1:0] sy1_r;
  logic [SYNC_PINS-1:0] sy2_r;
  logic                 hs_d_r;
  logic [7:0]           com1_r;
  logic [5:0]           clkdiv_r;
  logic                 spd_r;
  logic                 short_exp_r;
  logic                 strap_done_r;
  logic [1:0]           strap_cnt_r;
  logic [5:0]           div_cnt_r;
  logic [9:0]           hcnt_r;
  logic [9:0]           vcnt_r;
  logic                 vs_lat_r;
  logic                 vs_lat_d_r;
  csec_exp_t            state_r;
  logic [10:0]          pcnt_r;
  logic [9:0]           lcnt_r;
  logic [7:0]           rdata_r;
  csec_sync_t           sync_out_r;
  csec_sync_t           sync_oe_r;
  logic                 lv_r;
  logic                 prech_r;
  logic                 integ_r;

  wire hrst     = sy2_r[6];
  wire pd_hw    = sy2_r[5];
  wire frame_exposure_input_s   = sy2_r[4];
  wire hs_s     = sy2_r[3];
  wire vs_s     = sy2_r[2];
  wire [1:0] strap_s = sy2_r[1:0];

  wire slave    = com1_r[COM1_SLAVE_BIT];
  wire prog     = com1_r[COM1_PROG_BIT];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = a == ofs;
  endfunction

  wire wr_com1   = reg_wr & hit(reg_addr, ADDR_COM1);
  wire wr_clkdiv = reg_wr & hit(reg_addr, ADDR_CLKDIV);
  wire wr_ctrl   = reg_wr & hit(reg_addr, ADDR_CTRL);
  wire wr_stat   = reg_wr & hit(reg_addr, ADDR_STAT);
  wire srst_req  = wr_ctrl & reg_wdata[CTRL_SRST_BIT];
  wire reg_clear = hrst | srst_req;
  wire strap_load = ~strap_done_r & (strap_cnt_r == STRAP_SETTLE);

  // straps override a write in the same cycle
  wire [7:0] com1_strap = {com1_r[7], strap_s[STRAP_SLAVE_BIT], com1_r[5:3], strap_s[STRAP_PROG_BIT], com1_r[1:0]};
  wire [7:0] com1_nxt   = strap_load ? com1_strap : (wr_com1 ? reg_wdata : com1_r);
  wire [5:0] clkdiv_nxt = wr_clkdiv ? reg_wdata[5:0] : clkdiv_r;
  wire       spd_nxt    = wr_ctrl ? reg_wdata[CTRL_SPD_BIT] : spd_r;

  // pixel tick: one per (divider + 1) input clocks, none while hard powered down
  wire       pix_tick    = ~pd_hw & (div_cnt_r >= clkdiv_r);
  wire [5:0] div_cnt_nxt = (pd_hw | pix_tick) ? 6'h00 : div_cnt_r + 6'h01;
  wire       run         = pix_tick & ~spd_r;
  wire       tim_rst     = pd_hw | reg_clear;

  // line timing: own counter in master mode, edge of resynced pin in slave
  wire       hs_rise     = hs_s & ~hs_d_r;
  wire       h_last      = hcnt_r == 10'(LINE_PIX - 1);
  wire       v_last      = vcnt_r == 10'(FRAME_LINES - 1);
  wire       line_start  = slave ? hs_rise : (run & (hcnt_r == 10'h000));
  wire [9:0] hcnt_nxt    = (slave & hs_rise) ? 10'h000 :
                           (run & h_last & ~slave) ? 10'h000 :
                           (run & ~h_last) ? hcnt_r + 10'h001 : hcnt_r;
  wire       vs_rise     = vs_lat_r & ~vs_lat_d_r;
  wire [9:0] vcnt_nxt    = (slave & vs_rise) ? 10'h000 :
                           (line_start & v_last & ~slave) ? 10'h000 :
                           (line_start & ~v_last) ? vcnt_r + 10'h001 : vcnt_r;
  wire       in_window   = (hcnt_r >= 10'(ACT_START)) & (hcnt_r < 10'(ACT_START + ACT_PIX));

  // exposure sequencer; frame_exposure_input only looked at on line starts
  csec_exp_t state_nxt;
  logic [10:0] pcnt_nxt;
  logic [9:0]  lcnt_nxt;
  logic        short_set;
  always_comb
  begin
    state_nxt = state_r;
    pcnt_nxt  = pcnt_r;
    lcnt_nxt  = lcnt_r;
    short_set = 1'b0;
    unique case (state_r)
      EXP_IDLE:
      begin
        if (line_start & frame_exposure_input_s & prog)
        begin
          state_nxt = EXP_PRECH;
          pcnt_nxt  = 11'h000;
        end
      end
      EXP_PRECH:
      begin
        if (line_start & ~frame_exposure_input_s)
        begin
          short_set = 1'b1;
          state_nxt = EXP_DUMMY;
          lcnt_nxt  = 10'h000;
        end
        else if (run & (pcnt_r == 11'(PRECH_PIX - 1)))
          state_nxt = EXP_INTEG;
        else if (run)
          pcnt_nxt = pcnt_r + 11'h001;
      end
      EXP_INTEG:
      begin
        if (line_start & ~frame_exposure_input_s)
        begin
          state_nxt = EXP_DUMMY;
          lcnt_nxt  = 10'h000;
        end
      end
      EXP_DUMMY:
      begin
        if (line_start & (lcnt_r == 10'(DUMMY_LINES - 1)))
        begin
          state_nxt = EXP_READ;
          lcnt_nxt  = 10'h000;
        end
        else if (line_start)
          lcnt_nxt = lcnt_r + 10'h001;
      end
      EXP_READ:
      begin
        if (line_start & (lcnt_r == 10'(ACT_LINES - 1)))
          state_nxt = EXP_IDLE;
        else if (line_start)
          lcnt_nxt = lcnt_r + 10'h001;
      end
    endcase
    if (~prog)
      state_nxt = EXP_IDLE;
  end

  wire       hold_phase = (state_r == EXP_DUMMY) & (lcnt_r < 10'(HOLD_LINES));
  wire [7:0] stat_word  = {short_exp_r, hold_phase, pd_hw, spd_r, strap_done_r, 3'(state_r)};
  wire [7:0] rd_mux     = hit(reg_addr, ADDR_COM1)   ? com1_r :
                          hit(reg_addr, ADDR_CLKDIV) ? {2'b00, clkdiv_r} :
                          hit(reg_addr, ADDR_CTRL)   ? {6'h00, spd_r, 1'b0} :
                          hit(reg_addr, ADDR_STAT)   ? stat_word : 8'h00;
  // set wins over the clear written in the same cycle
  wire short_nxt = short_set | (short_exp_r & ~(wr_stat & reg_wdata[STAT_CLR_BIT]));

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy1_r  <= '0;
      sy2_r  <= '0;
      hs_d_r <= 1'b0;
    end
    else
    begin
      sy1_r  <= {reset_pin, power_down_pin, frame_exposure_input, sync_in.hs, sync_in.vs, strap_pins};
      sy2_r  <= sy1_r;
      hs_d_r <= hs_s;
    end
  end

  // bus registers survive hard power-down, not a reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      com1_r       <= COM1_RST;
      clkdiv_r     <= CLKDIV_RST;
      spd_r        <= SPD_RST;
      short_exp_r  <= 1'b0;
      strap_done_r <= 1'b0;
      strap_cnt_r  <= 2'h0;
    end
    else if (reg_clear)
    begin
      com1_r       <= COM1_RST;
      clkdiv_r     <= CLKDIV_RST;
      spd_r        <= SPD_RST;
      short_exp_r  <= 1'b0;
      strap_done_r <= 1'b0;
      strap_cnt_r  <= 2'h0;
    end
    else
    begin
      com1_r       <= com1_nxt;
      clkdiv_r     <= clkdiv_nxt;
      spd_r        <= spd_nxt;
      short_exp_r  <= short_nxt;
      strap_done_r <= strap_done_r | strap_load;
      strap_cnt_r  <= strap_load | strap_done_r ? strap_cnt_r : strap_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt_r  <= 6'h00;
      hcnt_r     <= 10'h000;
      vcnt_r     <= 10'h000;
      vs_lat_r   <= 1'b0;
      vs_lat_d_r <= 1'b0;
      state_r    <= EXP_IDLE;
      pcnt_r     <= 11'h000;
      lcnt_r     <= 10'h000;
    end
    else if (tim_rst)
    begin
      div_cnt_r  <= 6'h00;
      hcnt_r     <= 10'h000;
      vcnt_r     <= 10'h000;
      vs_lat_r   <= 1'b0;
      vs_lat_d_r <= 1'b0;
      state_r    <= EXP_IDLE;
      pcnt_r     <= 11'h000;
      lcnt_r     <= 10'h000;
    end
    else
    begin
      div_cnt_r  <= div_cnt_nxt;
      hcnt_r     <= hcnt_nxt;
      vcnt_r     <= vcnt_nxt;
      vs_lat_r   <= line_start ? vs_s : vs_lat_r;
      vs_lat_d_r <= vs_lat_r;
      state_r    <= state_nxt;
      pcnt_r     <= pcnt_nxt;
      lcnt_r     <= lcnt_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r    <= 8'h00;
      sync_out_r <= '0;
      sync_oe_r  <= '0;
      lv_r       <= 1'b0;
      prech_r    <= 1'b0;
      integ_r    <= 1'b0;
    end
    else
    begin
      rdata_r    <= reg_rd ? rd_mux : 8'h00;
      sync_out_r <= '{hs: ~slave & (hcnt_r < 10'(HS_PIX)), vs: ~slave & (vcnt_r < 10'(VS_LINES))};
      sync_oe_r  <= '{hs: ~slave, vs: ~slave};
      lv_r       <= (state_r == EXP_READ) & in_window;
      prech_r    <= state_r == EXP_PRECH;
      integ_r    <= state_r == EXP_INTEG;
    end
  end

  assign reg_rdata        = rdata_r;
  assign sync_out         = sync_out_r;
  assign sync_oe          = sync_oe_r;
  assign line_valid       = lv_r;
  assign precharge_active = prech_r;
  assign integrating      = integ_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_master_default;
    reg_clear |=> !com1_r[COM1_SLAVE_BIT];
  endproperty
  a_master_default: assert property (p_master_default) else $error("not master after reset");

  property p_slave_hiz;
    slave |=> (sync_oe == 2'b00);
  endproperty
  a_slave_hiz: assert property (p_slave_hiz) else $error("sync pins driven in slave mode");

  property p_master_drive;
    rst_n && !slave |=> (sync_oe == 2'b11);
  endproperty
  a_master_drive: assert property (p_master_drive) else $error("sync pins released in master mode");

  property p_vs_on_line;
    !line_start && !tim_rst |=> $stable(vs_lat_r);
  endproperty
  a_vs_on_line: assert property (p_vs_on_line) else $error("frame sync moved off a line edge");

  property p_prog_only;
    !prog |=> state_r == EXP_IDLE;
  endproperty
  a_prog_only: assert property (p_prog_only) else $error("exposure left idle without progressive scan");

  property p_start_prech;
    state_r == EXP_IDLE && line_start && frame_exposure_input_s && prog && !tim_rst |=> state_r == EXP_PRECH && pcnt_r == 11'h000;
  endproperty
  a_start_prech: assert property (p_start_prech) else $error("precharge not started");

  property p_integ_hold;
    state_r == EXP_INTEG && !line_start && prog && !tim_rst |=> state_r == EXP_INTEG;
  endproperty
  a_integ_hold: assert property (p_integ_hold) else $error("integration ended off a line edge");

  property p_dummy_lines;
    state_r == EXP_DUMMY && line_start && lcnt_r == 10'(DUMMY_LINES - 1) && prog && !tim_rst
      |=> state_r == EXP_READ ##1 !$past(line_valid);
  endproperty
  a_dummy_lines: assert property (p_dummy_lines) else $error("readout not after eight lines");

  property p_read_valid;
    state_r == EXP_READ && in_window |=> line_valid;
  endproperty
  a_read_valid: assert property (p_read_valid) else $error("readout line not marked valid");

  property p_hw_reset;
    hrst |=> com1_r == COM1_RST && clkdiv_r == CLKDIV_RST && !spd_r;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("reset pin left registers set");

  property p_sw_reset;
    srst_req && !hrst |=> clkdiv_r == CLKDIV_RST && com1_r == COM1_RST;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("bus reset left registers set");

  property p_hw_pd;
    pd_hw |-> !pix_tick ##1 state_r == EXP_IDLE && hcnt_r == 10'h000;
  endproperty
  a_hw_pd: assert property (p_hw_pd) else $error("timing ran in hard power-down");

  property p_sw_pd;
    spd_r && !tim_rst && !slave |=> $stable(hcnt_r);
  endproperty
  a_sw_pd: assert property (p_sw_pd) else $error("timing ran in soft power-down");

  property p_strap;
    strap_load && !reg_clear |=> com1_r[COM1_SLAVE_BIT] == $past(strap_s[STRAP_SLAVE_BIT]) && strap_done_r;
  endproperty
  a_strap: assert property (p_strap) else $error("strap not loaded");

  property p_read_back;
    reg_rd && hit(reg_addr, ADDR_CLKDIV) |=> reg_rdata == {2'b00, $past(clkdiv_r)};
  endproperty
  a_read_back: assert property (p_read_back) else $error("divider read back wrong");

  property p_divider;
    pix_tick && clkdiv_r != 6'h00 && !reg_clear && !wr_clkdiv |=> !pix_tick;
  endproperty
  a_divider: assert property (p_divider) else $error("pixel tick too frequent");
endmodule

// File: csec_master_model.sv
// external timing master model: slave syncs and frame exposure request
`timescale 1ns/10ps
module csec_master_model
  import csec_pkg::*;
#(
  parameter int LINE  = 64,
  parameter int HS_W  = 8,
  parameter int FRAME = 20,
  parameter int VS_W  = 3
)
(
  input  wire logic        core_clk,
  input  wire logic        slave_en,
  input  wire logic        exp_go,
  input  wire logic [15:0] exp_len,
  output csec_sync_t       sync_drv,
  output logic             frame_exposure_input
);
  int pix  = 0;
  int lin  = 0;
  int left = 0;

  initial
  begin
    sync_drv = '0;
    frame_exposure_input = 1'b0;
  end

  always @(posedge core_clk)
  begin
    pix <= (pix == LINE - 1) ? 0 : pix + 1;
    if (pix == LINE - 1)
      lin <= (lin == FRAME - 1) ? 0 : lin + 1;
    // released lines toggle so a stale level never passes for a drive
    sync_drv.hs <= slave_en ? (pix < HS_W) : ~sync_drv.hs;
    sync_drv.vs <= slave_en ? (lin < VS_W) : ~sync_drv.vs;
    if (exp_go)
      left <= exp_len;
    else if (left > 0)
      left <= left - 1;
    // level held for the whole requested span
    frame_exposure_input <= exp_go || left > 1;
  end
endmodule

// File: camera_sync_exposure_control_bench.sv
// self-checking bench of the sync and exposure control block
`timescale 1ns/10ps
module camera_sync_exposure_control_bench
  import csec_pkg::*;
;
  localparam int LP = 64;
  localparam int AP = 16;
  localparam int AL = 4;
  localparam int HW = 8;
  localparam int FL = 20;
  localparam int VW = 3;
  localparam int AS = 4;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        reset_pin = 1'b0;
  logic        power_down_pin = 1'b0;
  logic        frame_exposure_input;
  logic [1:0]  strap_pins = 2'h0;
  csec_sync_t  pin;
  csec_sync_t  sync_out;
  csec_sync_t  sync_oe;
  csec_sync_t  m_sync;
  logic        line_valid;
  logic        precharge_active;
  logic        integrating;
  logic        slave_en = 1'b0;
  logic        exp_go = 1'b0;
  logic [15:0] exp_len = 16'h0000;
  logic        rd_q = 1'b0;
  logic        hs_q = 1'b0;
  logic        pre_seen = 1'b0;
  logic [15:0] note;
  logic [15:0] note_q[$];
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          hs_t = 0;
  int          hs_p = 0;
  logic [7:0]  rnd;
  int          seed = 32'h2a1bb54b;

  always #50 core_clk = ~core_clk;
  // wire level: device when enabled, else the external master
  assign pin.hs = sync_oe.hs ? sync_out.hs : m_sync.hs;
  assign pin.vs = sync_oe.vs ? sync_out.vs : m_sync.vs;

  csec_top #(.LINE_PIX(LP), .HS_PIX(HW), .FRAME_LINES(FL), .VS_LINES(VW), .ACT_START(AS), .ACT_PIX(AP),
    .ACT_LINES(AL)) u_csec_top (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reset_pin(reset_pin),
    .power_down_pin(power_down_pin), .frame_exposure_input(frame_exposure_input), .strap_pins(strap_pins),
    .sync_in(pin), .sync_out(sync_out), .sync_oe(sync_oe), .line_valid(line_valid),
    .precharge_active(precharge_active), .integrating(integrating));

  csec_master_model #(.LINE(LP), .HS_W(HW), .FRAME(FL), .VS_W(VW)) u_csec_master_model (.core_clk(core_clk),
    .slave_en(slave_en), .exp_go(exp_go), .exp_len(exp_len), .sync_drv(m_sync),
    .frame_exposure_input(frame_exposure_input));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // mask in the upper byte of the note hides bits the check leaves open
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    note_q.push_back({m, e});
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic pulse(input int len);
    exp_len <= 16'(len);
    exp_go <= 1'b1;
    @(posedge core_clk);
    exp_go <= 1'b0;
  endtask

  task automatic expose(input int extra, input logic slv);
    int i;
    int t0;
    int t1;
    int lv;
    pulse(PRECH_PIX + 2 * LP + extra);
    for (i = 0; i < 3 * LP && !precharge_active; i++) @(posedge core_clk);
    t0 = cyc;
    check(precharge_active, 1);
    if (slv)
      check((t0 - hs_t) >= 1 && (t0 - hs_t) <= 6, 1);
    for (i = 0; i < PRECH_PIX + LP && !integrating; i++) @(posedge core_clk);
    check(cyc - t0, PRECH_PIX);
    for (i = 0; i < 4 * LP + extra && integrating; i++) @(posedge core_clk);
    t1 = cyc;
    for (i = 0; i < 12 * LP && !line_valid; i++) @(posedge core_clk);
    check((cyc - t1) > 8 * LP && (cyc - t1) <= 9 * LP, 1);
    lv = 0;
    repeat ((AL + 1) * LP)
    begin
      if (line_valid === 1'b1)
        lv++;
      @(posedge core_clk);
    end
    check(lv, AL * AP);
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    hs_q <= pin.hs;
    // last two line sync rises give the line period
    if (pin.hs && !hs_q)
    begin
      hs_t <= cyc;
      hs_p <= hs_t;
    end
    if (precharge_active)
      pre_seen <= 1'b1;
    rd_q <= reg_rd;
    if (rd_q)
    begin
      note = note_q.pop_front();
      check(reg_rdata & note[15:8], note[7:0]);
    end
  end

  initial
  begin
    #(100 * 40000);
    err_total++;
    test_done();
  end

  initial
  begin
    tick(12);
    rst_n <= 1'b1;
    tick(5);
    check(sync_oe, 2'b11);
    rd(ADDR_COM1, 8'hff, COM1_RST);
    rd(8'h07, 8'hff, 8'h00);
    // own variable: the read checker overwrites note at every read
    rnd = 8'($random(seed)) & 8'h3f;
    wr(ADDR_CLKDIV, rnd);
    rd(ADDR_CLKDIV, 8'hff, rnd);
    wr(8'h07, 8'h5a);
    rd(8'h07, 8'hff, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    tick(6);
    rd(ADDR_CLKDIV, 8'hff, 8'h00);
    rd(ADDR_CTRL, 8'h01, 8'h00);
    wr(ADDR_CTRL, 8'h02);
    rd(ADDR_CTRL, 8'h02, 8'h02);
    rd(ADDR_STAT, 8'h10, 8'h10);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CLKDIV, 8'h05);
    strap_pins <= 2'h2;
    reset_pin <= 1'b1;
    tick(3);
    reset_pin <= 1'b0;
    tick(10);
    rd(ADDR_CLKDIV, 8'hff, 8'h00);
    rd(ADDR_COM1, 8'hff, 8'h04);
    strap_pins <= 2'h0;
    // progressive clear: request must be ignored
    wr(ADDR_COM1, 8'h00);
    tick(4);
    pre_seen <= 1'b0;
    pulse(3 * LP);
    tick(4 * LP);
    check(pre_seen, 0);
    check(hs_t - hs_p, LP);
    wr(ADDR_CLKDIV, 8'h01);
    tick(6 * LP);
    check(hs_t - hs_p, 2 * LP);
    wr(ADDR_CLKDIV, 8'h00);
    wr(ADDR_COM1, 8'h04);
    tick(2);
    // request dropped inside precharge: sticky flag, dummy lines in hold phase
    pulse(2 * LP);
    tick(5 * LP);
    rd(ADDR_STAT, 8'hc7, 8'hc3);
    wr(ADDR_STAT, 8'h80);
    rd(ADDR_STAT, 8'h80, 8'h00);
    tick(12 * LP);
    expose($unsigned($random(seed)) % 64, 1'b0);
    wr(ADDR_COM1, 8'h44);
    slave_en <= 1'b1;
    tick(3);
    check(sync_oe, 2'b00);
    check(sync_out, 2'b00);
    tick(2 * LP);
    expose($unsigned($random(seed)) % 64, 1'b1);
    // hard power-down in mid precharge must drop the phase at once
    pulse(PRECH_PIX);
    tick(3 * LP);
    check(precharge_active, 1);
    power_down_pin <= 1'b1;
    tick(6);
    check({precharge_active, integrating, line_valid}, 0);
    rd(ADDR_STAT, 8'h27, 8'h20);
    rd(ADDR_COM1, 8'hff, 8'h44);
    power_down_pin <= 1'b0;
    tick(4);
    test_done();
  end
endmodule
